// [hw/tmon_pkg.sv]
package tmon_pkg;

    // register indices, read side and write side
    localparam logic [7:0] IDX_LOCAL_HI  = 8'h00;
    localparam logic [7:0] IDX_REMOTE_HI = 8'h01;
    localparam logic [7:0] IDX_FLAGS     = 8'h02;
    localparam logic [7:0] IDX_SETUP_RD  = 8'h03;
    localparam logic [7:0] IDX_RATE_RD   = 8'h04;
    localparam logic [7:0] IDX_LUB_RD    = 8'h05;
    localparam logic [7:0] IDX_LLB_RD    = 8'h06;
    localparam logic [7:0] IDX_RUB_RD    = 8'h07;
    localparam logic [7:0] IDX_RLB_RD    = 8'h08;
    localparam logic [7:0] IDX_SETUP_WR  = 8'h09;
    localparam logic [7:0] IDX_RATE_WR   = 8'h0a;
    localparam logic [7:0] IDX_LUB_WR    = 8'h0b;
    localparam logic [7:0] IDX_LLB_WR    = 8'h0c;
    localparam logic [7:0] IDX_RUB_WR    = 8'h0d;
    localparam logic [7:0] IDX_RLB_WR    = 8'h0e;
    localparam logic [7:0] IDX_TRIGGER   = 8'h0f;
    localparam logic [7:0] IDX_REMOTE_LO = 8'h10;
    localparam logic [7:0] IDX_OFS_HI    = 8'h11;
    localparam logic [7:0] IDX_OFS_LO    = 8'h12;
    localparam logic [7:0] IDX_RUB_LO    = 8'h13;
    localparam logic [7:0] IDX_RLB_LO    = 8'h14;
    localparam logic [7:0] IDX_LOCAL_LO  = 8'h15;
    localparam logic [7:0] IDX_RCRIT     = 8'h19;
    localparam logic [7:0] IDX_LCRIT     = 8'h20;
    localparam logic [7:0] IDX_HYST      = 8'h21;
    localparam logic [7:0] IDX_FAULT     = 8'h22;
    localparam logic [7:0] IDX_IDEAL     = 8'h23;
    localparam logic [7:0] IDX_SMOOTH    = 8'h24;
    localparam logic [7:0] IDX_MAKER     = 8'hfe;

    // reset values
    localparam logic [7:0] RST_ZERO  = 8'h00;
    localparam logic [7:0] RST_RATE  = 8'h08;
    localparam logic [7:0] RST_UPPER = 8'h55;
    localparam logic [7:0] RST_CRIT  = 8'h6e;
    localparam logic [7:0] RST_HYST  = 8'h0a;
    localparam logic [7:0] RST_FAULT = 8'h01;

    // writable bits and fixed bits
    localparam logic [7:0] SETUP_WMASK  = 8'he4;
    localparam logic [7:0] RATE_WMASK   = 8'h0f;
    localparam logic [7:0] FAULT_WMASK  = 8'h8e;
    localparam logic [7:0] FAULT_FIXED  = 8'h01;
    localparam logic [7:0] SMOOTH_WMASK = 8'h03;
    localparam logic [7:0] NIB_MASK     = 8'hf0;
    localparam logic [3:0] NIB_ZERO     = 4'h0;

    // field positions
    localparam int SETUP_MASK_BIT  = 7;
    localparam int SETUP_SHUT_BIT  = 6;
    localparam int SETUP_PIN_BIT   = 5;
    localparam int SETUP_RANGE_BIT = 2;
    localparam int FLAG_BUSY_BIT   = 7;
    localparam int FAULT_TO_BIT    = 7;

    // sticky flag group, bits 6..2 of the flag register
    localparam logic [4:0] STICKY_ALL  = 5'h1f;
    localparam logic [4:0] STICKY_OPEN = 5'h01;

    typedef enum logic [1:0] {
        KIND_INDEX     = 2'b00,
        KIND_WRITE     = 2'b01,
        KIND_READ      = 2'b10,
        KIND_ALERT_ACK = 2'b11
    } xfer_kind_t;

    typedef enum logic [1:0] {
        LOCK_NONE = 2'b00,
        LOCK_LOW  = 2'b01,
        LOCK_HIGH = 2'b10
    } lock_t;

    typedef struct packed {
        xfer_kind_t kind;
        logic [7:0] data;
    } xfer_t;

    typedef struct packed {
        logic [11:0] local_value;
        logic [11:0] remote_value;
        logic        diode_open;
    } conv_result_t;

    typedef struct packed {
        logic        ext_range;
        logic [3:0]  rate_code;
        logic [7:0]  ideality_value;
        logic [1:0]  smoothing_sel;
        logic [11:0] remote_offset;
        logic        bus_timeout_enable;
        logic [2:0]  fault_count_sel;
    } conv_setup_t;

endpackage

// [hw/temp_monitor_regs.sv]
// Operation
// [R1] 8-bit index picks the register; first byte of each write reloads it.
// [R2] index resets to zero, so first read returns local high byte.
// [R3] setup registers read at one index and are written at another.
// [R4] any write to index 0f starts one conversion; data is dropped.
// [R5] local result is 12 bits: high byte at 00, low nibble at 15.
// [R6] remote result is 12 bits: high at 01, low nibble at 10; rest zero.
// [R7] low four result bits are sixteenths of a degree.
// [R8] results are read-only, reset to zero, refreshed by each conversion.
// [R9] reading one byte of a pair freezes the other until it is read.
// [R10] reading any other register releases the pair freeze.
// [R11] flag register at 02: busy, four limit flags, open, two critical flags.
// [R12] busy bit mirrors converter activity.
// [R13] alert mode: five flags sticky; second-critical mode: only open sticky.
// [R14] a flag read clears a sticky flag only once its cause is gone.
// [R15] alert mode: any sticky flag sets the latch, driving the pin low.
// [R16] latch clears only on alert response with flags and causes clear.
// [R17] critical flags follow temperature against critical limits, no read needed.
// [R18] critical pin is low while either channel is over critical.
// [R19] critical release at limit minus hysteresis; hysteresis resets to 0a.
// [R20] both critical limits reset to 6e, same read and write index.
// [R21] second-critical mode: high limits drive pin with hysteresis, low ignored.
// [R22] remote bounds are 12 bits, low nibbles at 13 and 14.
// [R23] remote offset is 12 bits at 11 and 12, reset to zero.
// [R24] reads use the last written index, held across reads.
// [R25] mask bit silences pin in alert mode only.
// [R26] range bit selects standard or extended result coding.
// [R27] trigger in shutdown runs one cycle, then converter stays idle.
// [R28] read-only maker code at fe; bad writes dropped, reserved bits zero.
// [R29] each result is compared with bounds to raise over or under flags.
`timescale 1ns/100ps
module temp_monitor_regs #(
    parameter logic [7:0] MAKER_CODE    = 8'ha7,  // arbitrary value
    parameter logic [7:0] RESPONSE_BYTE = 8'h00
) (
    input  wire logic                  CLK,
    input  wire logic                  RSTN,
    input  wire logic                  LINK_CLK,
    input  wire logic                  XFER_VALID,
    input  wire tmon_pkg::xfer_t       XFER_REQ,
    output      logic                  XFER_BUSY,
    output      logic                  XFER_DONE,
    output      logic [7:0]            XFER_RDATA,
    input  wire logic                  CONV_BUSY,
    input  wire logic                  CONV_DONE,
    input  wire tmon_pkg::conv_result_t CONV_RESULT,
    output      logic                  CONV_START,
    output      logic                  CONV_RUN,
    output      tmon_pkg::conv_setup_t CONV_SETUP,
    output      logic                  CRITICAL_OUT_N,
    output      logic                  EVENT_OUT_N
);

    // ---------------- link domain ----------------
    tmon_pkg::xfer_t xfer_q;
    logic            req_tgl_q;
    logic            ack_s1_q;
    logic            ack_s2_q;
    logic            ack_seen_q;
    logic            link_busy_q;
    logic            link_done_q;
    logic [7:0]      link_rdata_q;

    // core-side signals
    logic            req_s1_q;
    logic            req_s2_q;
    logic            req_seen_q;
    logic            ack_tgl_q;
    logic [7:0]      rdata_q;
    logic            fire;

    // capture a request and flip the toggle; data held until the answer
    always_ff @(posedge LINK_CLK or negedge RSTN) begin
        if (!RSTN) begin
            xfer_q      <= '0;
            req_tgl_q   <= 1'b0;
            link_busy_q <= 1'b0;
        end else if (XFER_VALID && !link_busy_q) begin
            xfer_q      <= XFER_REQ;
            req_tgl_q   <= ~req_tgl_q;
            link_busy_q <= 1'b1;
        end else if (ack_s2_q != ack_seen_q) begin
            link_busy_q <= 1'b0;
        end
    end

    // answer toggle back into link domain
    always_ff @(posedge LINK_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ack_s1_q     <= 1'b0;
            ack_s2_q     <= 1'b0;
            ack_seen_q   <= 1'b0;
            link_done_q  <= 1'b0;
            link_rdata_q <= 8'h00;
        end else begin
            ack_s1_q    <= ack_tgl_q;
            ack_s2_q    <= ack_s1_q;
            ack_seen_q  <= ack_s2_q;
            link_done_q <= (ack_s2_q != ack_seen_q);
            if (ack_s2_q != ack_seen_q) begin
                link_rdata_q <= rdata_q;  // stable until next request
            end
        end
    end

    assign XFER_BUSY  = link_busy_q;
    assign XFER_DONE  = link_done_q;
    assign XFER_RDATA = link_rdata_q;

    // ---------------- core domain ----------------
    // request toggle synchroniser
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            req_s1_q   <= 1'b0;
            req_s2_q   <= 1'b0;
            req_seen_q <= 1'b0;
        end else begin
            req_s1_q   <= req_tgl_q;
            req_s2_q   <= req_s1_q;
            req_seen_q <= req_s2_q;
        end
    end

    assign fire = (req_s2_q != req_seen_q);

    logic is_wr;
    logic is_rd;
    logic is_ack;
    assign is_wr  = fire && (xfer_q.kind == tmon_pkg::KIND_WRITE);
    assign is_rd  = fire && (xfer_q.kind == tmon_pkg::KIND_READ);
    assign is_ack = fire && (xfer_q.kind == tmon_pkg::KIND_ALERT_ACK);

    logic [7:0] index_q;
    // [R1] index reload
    // [R2] zero after reset
    // [R24] held across reads
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            index_q <= tmon_pkg::RST_ZERO;
        end else if (fire && xfer_q.kind == tmon_pkg::KIND_INDEX) begin
            index_q <= xfer_q.data;
        end
    end

    // writable registers
    logic [7:0] setup_q, rate_q, lub_q, llb_q, rub_hi_q, rlb_hi_q;
    logic [7:0] ofs_hi_q, ofs_lo_q, rub_lo_q, rlb_lo_q;
    logic [7:0] rcrit_q, lcrit_q, hyst_q, fault_q, ideal_q, smooth_q;

    // [R3] split write indices
    // [R20] critical limit defaults
    // [R22] remote bound nibbles
    // [R23] offset pair
    // [R28] unlisted writes dropped
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            setup_q  <= tmon_pkg::RST_ZERO;
            rate_q   <= tmon_pkg::RST_RATE;
            lub_q    <= tmon_pkg::RST_UPPER;
            llb_q    <= tmon_pkg::RST_ZERO;
            rub_hi_q <= tmon_pkg::RST_UPPER;
            rlb_hi_q <= tmon_pkg::RST_ZERO;
            ofs_hi_q <= tmon_pkg::RST_ZERO;
            ofs_lo_q <= tmon_pkg::RST_ZERO;
            rub_lo_q <= tmon_pkg::RST_ZERO;
            rlb_lo_q <= tmon_pkg::RST_ZERO;
            rcrit_q  <= tmon_pkg::RST_CRIT;
            lcrit_q  <= tmon_pkg::RST_CRIT;
            hyst_q   <= tmon_pkg::RST_HYST;
            fault_q  <= tmon_pkg::RST_FAULT;
            ideal_q  <= tmon_pkg::RST_ZERO;
            smooth_q <= tmon_pkg::RST_ZERO;
        end else if (is_wr) begin
            case (index_q)
                tmon_pkg::IDX_SETUP_WR: setup_q  <= xfer_q.data & tmon_pkg::SETUP_WMASK;
                tmon_pkg::IDX_RATE_WR:  rate_q   <= xfer_q.data & tmon_pkg::RATE_WMASK;
                tmon_pkg::IDX_LUB_WR:   lub_q    <= xfer_q.data;
                tmon_pkg::IDX_LLB_WR:   llb_q    <= xfer_q.data;
                tmon_pkg::IDX_RUB_WR:   rub_hi_q <= xfer_q.data;
                tmon_pkg::IDX_RLB_WR:   rlb_hi_q <= xfer_q.data;
                tmon_pkg::IDX_OFS_HI:   ofs_hi_q <= xfer_q.data;
                tmon_pkg::IDX_OFS_LO:   ofs_lo_q <= xfer_q.data & tmon_pkg::NIB_MASK;
                tmon_pkg::IDX_RUB_LO:   rub_lo_q <= xfer_q.data & tmon_pkg::NIB_MASK;
                tmon_pkg::IDX_RLB_LO:   rlb_lo_q <= xfer_q.data & tmon_pkg::NIB_MASK;
                tmon_pkg::IDX_RCRIT:    rcrit_q  <= xfer_q.data;
                tmon_pkg::IDX_LCRIT:    lcrit_q  <= xfer_q.data;
                tmon_pkg::IDX_HYST:     hyst_q   <= xfer_q.data;
                tmon_pkg::IDX_FAULT:    fault_q  <= (xfer_q.data & tmon_pkg::FAULT_WMASK) | tmon_pkg::FAULT_FIXED;
                tmon_pkg::IDX_IDEAL:    ideal_q  <= xfer_q.data;
                tmon_pkg::IDX_SMOOTH:   smooth_q <= xfer_q.data & tmon_pkg::SMOOTH_WMASK;
                default: ;
            endcase
        end
    end

    // per-channel limits, channel 0 local, channel 1 remote
    logic [11:0] hi_lim [2];
    logic [11:0] lo_lim [2];
    logic [7:0]  crit_lim [2];
    assign hi_lim[0]   = {lub_q, tmon_pkg::NIB_ZERO};
    assign lo_lim[0]   = {llb_q, tmon_pkg::NIB_ZERO};
    assign hi_lim[1]   = {rub_hi_q, rub_lo_q[7:4]};
    assign lo_lim[1]   = {rlb_hi_q, rlb_lo_q[7:4]};
    assign crit_lim[0] = lcrit_q;
    assign crit_lim[1] = rcrit_q;

    logic [11:0] fresh [2];
    assign fresh[0] = CONV_RESULT.local_value;
    assign fresh[1] = CONV_RESULT.remote_value;

    logic [7:0] res_hi_idx [2];
    logic [7:0] res_lo_idx [2];
    assign res_hi_idx[0] = tmon_pkg::IDX_LOCAL_HI;
    assign res_lo_idx[0] = tmon_pkg::IDX_LOCAL_LO;
    assign res_hi_idx[1] = tmon_pkg::IDX_REMOTE_HI;
    assign res_lo_idx[1] = tmon_pkg::IDX_REMOTE_LO;

    logic [7:0]  res_hi_q [2];
    logic [3:0]  res_lo_q [2];
    logic [11:0] latest_q [2];
    logic [1:0]  over_c, under_c, crit_q, high2_q;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            tmon_pkg::lock_t lock_q;
            logic [7:0]      crit_rel;
            logic [11:0]     high_rel;

            // [R9] pair freeze on first byte read
            // [R10] other reads release
            always_ff @(posedge CLK or negedge RSTN) begin
                if (!RSTN) begin
                    lock_q <= tmon_pkg::LOCK_NONE;
                end else if (is_rd) begin
                    if (index_q == res_hi_idx[ch]) begin
                        lock_q <= (lock_q == tmon_pkg::LOCK_HIGH) ? tmon_pkg::LOCK_NONE : tmon_pkg::LOCK_LOW;
                    end else if (index_q == res_lo_idx[ch]) begin
                        lock_q <= (lock_q == tmon_pkg::LOCK_LOW) ? tmon_pkg::LOCK_NONE : tmon_pkg::LOCK_HIGH;
                    end else begin
                        lock_q <= tmon_pkg::LOCK_NONE;
                    end
                end
            end

            // [R5] [R6] [R8] result bytes, updated unless frozen
            always_ff @(posedge CLK or negedge RSTN) begin
                if (!RSTN) begin
                    res_hi_q[ch] <= tmon_pkg::RST_ZERO;
                    res_lo_q[ch] <= tmon_pkg::NIB_ZERO;
                    latest_q[ch] <= '0;
                end else if (CONV_DONE) begin
                    latest_q[ch] <= fresh[ch];
                    if (lock_q != tmon_pkg::LOCK_HIGH) begin
                        res_hi_q[ch] <= fresh[ch][11:4];
                    end
                    if (lock_q != tmon_pkg::LOCK_LOW) begin
                        res_lo_q[ch] <= fresh[ch][3:0];
                    end
                end
            end

            // [R29] bound comparison
            assign over_c[ch]  = latest_q[ch] > hi_lim[ch];
            assign under_c[ch] = latest_q[ch] < lo_lim[ch];

            // release points, clamped at zero
            assign crit_rel = (crit_lim[ch] > hyst_q) ? crit_lim[ch] - hyst_q : tmon_pkg::RST_ZERO;
            assign high_rel = (hi_lim[ch] > {hyst_q, tmon_pkg::NIB_ZERO}) ?
                              hi_lim[ch] - {hyst_q, tmon_pkg::NIB_ZERO} : '0;

            // [R17] [R19] critical with hysteresis
            // [R21] high limit with same hysteresis
            always_ff @(posedge CLK or negedge RSTN) begin
                if (!RSTN) begin
                    crit_q[ch]  <= 1'b0;
                    high2_q[ch] <= 1'b0;
                end else begin
                    if (latest_q[ch] > {crit_lim[ch], tmon_pkg::NIB_ZERO}) begin
                        crit_q[ch] <= 1'b1;
                    end else if (latest_q[ch] <= {crit_rel, tmon_pkg::NIB_ZERO}) begin
                        crit_q[ch] <= 1'b0;
                    end
                    if (latest_q[ch] > hi_lim[ch]) begin
                        high2_q[ch] <= 1'b1;
                    end else if (latest_q[ch] <= high_rel) begin
                        high2_q[ch] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    logic pin2_mode;
    logic open_q;
    assign pin2_mode = setup_q[tmon_pkg::SETUP_PIN_BIT];

    // diode state from the last conversion
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            open_q <= 1'b0;
        end else if (CONV_DONE) begin
            open_q <= CONV_RESULT.diode_open;
        end
    end

    // causes for flag bits 6..2
    logic [4:0] cause;
    logic [4:0] sticky;
    logic [4:0] flag_q;
    logic       flags_read;
    assign cause = pin2_mode ? {high2_q[0], under_c[0], high2_q[1], under_c[1], open_q}
                             : {over_c[0], under_c[0], over_c[1], under_c[1], open_q};
    assign sticky = pin2_mode ? tmon_pkg::STICKY_OPEN : tmon_pkg::STICKY_ALL;
    assign flags_read = is_rd && (index_q == tmon_pkg::IDX_FLAGS);

    // [R13] sticky set per mode
    // [R14] read clears only absent causes
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            flag_q <= '0;
        end else begin
            flag_q <= cause | (flag_q & sticky & ~{5{flags_read}});
        end
    end

    logic latch_q;
    // [R15] latch set by any flag
    // [R16] cleared only by alert response
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            latch_q <= 1'b0;
        end else if (!pin2_mode && (|flag_q)) begin
            latch_q <= 1'b1;
        end else if (is_ack && !(|flag_q) && !(|cause)) begin
            latch_q <= 1'b0;
        end
    end

    // read data mux
    logic [7:0] rd_mux;
    // [R11] [R12] flag layout and busy
    // [R7] fraction nibble in upper bits
    // [R28] maker code and zero fill
    always_comb begin
        rd_mux = 8'h00;
        case (index_q)
            tmon_pkg::IDX_LOCAL_HI:  rd_mux = res_hi_q[0];
            tmon_pkg::IDX_REMOTE_HI: rd_mux = res_hi_q[1];
            tmon_pkg::IDX_FLAGS:     rd_mux = {CONV_BUSY, flag_q, crit_q[1], crit_q[0]};
            tmon_pkg::IDX_SETUP_RD:  rd_mux = setup_q;
            tmon_pkg::IDX_RATE_RD:   rd_mux = rate_q;
            tmon_pkg::IDX_LUB_RD:    rd_mux = lub_q;
            tmon_pkg::IDX_LLB_RD:    rd_mux = llb_q;
            tmon_pkg::IDX_RUB_RD:    rd_mux = rub_hi_q;
            tmon_pkg::IDX_RLB_RD:    rd_mux = rlb_hi_q;
            tmon_pkg::IDX_REMOTE_LO: rd_mux = {res_lo_q[1], tmon_pkg::NIB_ZERO};
            tmon_pkg::IDX_OFS_HI:    rd_mux = ofs_hi_q;
            tmon_pkg::IDX_OFS_LO:    rd_mux = ofs_lo_q;
            tmon_pkg::IDX_RUB_LO:    rd_mux = rub_lo_q;
            tmon_pkg::IDX_RLB_LO:    rd_mux = rlb_lo_q;
            tmon_pkg::IDX_LOCAL_LO:  rd_mux = {res_lo_q[0], tmon_pkg::NIB_ZERO};
            tmon_pkg::IDX_RCRIT:     rd_mux = rcrit_q;
            tmon_pkg::IDX_LCRIT:     rd_mux = lcrit_q;
            tmon_pkg::IDX_HYST:      rd_mux = hyst_q;
            tmon_pkg::IDX_FAULT:     rd_mux = fault_q;
            tmon_pkg::IDX_IDEAL:     rd_mux = ideal_q;
            tmon_pkg::IDX_SMOOTH:    rd_mux = smooth_q;
            tmon_pkg::IDX_MAKER:     rd_mux = MAKER_CODE;
            default:                 rd_mux = 8'h00;
        endcase
    end

    // answer register and toggle back to the link
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rdata_q   <= 8'h00;
            ack_tgl_q <= 1'b0;
        end else if (fire) begin
            ack_tgl_q <= ~ack_tgl_q;
            if (is_rd) begin
                rdata_q <= rd_mux;
            end else if (is_ack) begin
                rdata_q <= RESPONSE_BYTE;
            end
        end
    end

    // converter control outputs
    // [R4] trigger write starts one run
    // [R27] shutdown keeps run low
    // [R26] range bit to converter
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            CONV_START <= 1'b0;
            CONV_RUN   <= 1'b0;
            CONV_SETUP <= '0;
        end else begin
            CONV_START <= is_wr && (index_q == tmon_pkg::IDX_TRIGGER);
            CONV_RUN   <= !setup_q[tmon_pkg::SETUP_SHUT_BIT];
            CONV_SETUP.ext_range          <= setup_q[tmon_pkg::SETUP_RANGE_BIT];
            CONV_SETUP.rate_code          <= rate_q[3:0];
            CONV_SETUP.ideality_value     <= ideal_q;
            CONV_SETUP.smoothing_sel      <= smooth_q[1:0];
            CONV_SETUP.remote_offset      <= {ofs_hi_q, ofs_lo_q[7:4]};
            CONV_SETUP.bus_timeout_enable <= fault_q[tmon_pkg::FAULT_TO_BIT];
            CONV_SETUP.fault_count_sel    <= fault_q[3:1];
        end
    end

    // pin drivers, active low
    // [R18] critical pin
    // [R21] second-critical pin
    // [R25] mask only in alert mode
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            CRITICAL_OUT_N <= 1'b1;
            EVENT_OUT_N    <= 1'b1;
        end else begin
            CRITICAL_OUT_N <= ~(|crit_q);
            EVENT_OUT_N    <= pin2_mode ? ~(|high2_q)
                                        : ~(latch_q && !setup_q[tmon_pkg::SETUP_MASK_BIT]);
        end
    end

endmodule

// [verif/temp_monitor_regs_assertions.sv]
`timescale 1ns/100ps
module temp_monitor_regs_assertions (
    input wire logic       CLK,
    input wire logic       RSTN,
    input wire logic       LINK_CLK,
    input wire logic       XFER_VALID,
    input wire logic       XFER_BUSY,
    input wire logic       XFER_DONE,
    input wire logic [7:0] XFER_RDATA,
    input wire logic       CONV_START
);
    // link handshake: take, hold, answer
    property p_take; @(posedge LINK_CLK) disable iff (!RSTN) XFER_VALID && !XFER_BUSY |=> XFER_BUSY; endproperty
    a_take: assert property (p_take) else $error("request not taken");
    property p_hold; @(posedge LINK_CLK) disable iff (!RSTN) XFER_BUSY |=> XFER_BUSY || XFER_DONE; endproperty
    a_hold: assert property (p_hold) else $error("busy dropped early");
    property p_answer; @(posedge LINK_CLK) disable iff (!RSTN) $rose(XFER_BUSY) |-> ##[3:6] XFER_DONE; endproperty
    a_answer: assert property (p_answer) else $error("answer late");
    property p_free; @(posedge LINK_CLK) disable iff (!RSTN) XFER_DONE |-> !XFER_BUSY; endproperty
    a_free: assert property (p_free) else $error("busy with done");
    property p_pulse; @(posedge LINK_CLK) disable iff (!RSTN) XFER_DONE |=> !XFER_DONE; endproperty
    a_pulse: assert property (p_pulse) else $error("done too long");
    property p_cause; @(posedge LINK_CLK) disable iff (!RSTN) $rose(XFER_DONE) |-> $past(XFER_BUSY); endproperty
    a_cause: assert property (p_cause) else $error("done without request");
    property p_rdata; @(posedge LINK_CLK) disable iff (!RSTN) $changed(XFER_RDATA) |-> XFER_DONE; endproperty
    a_rdata: assert property (p_rdata) else $error("read byte moved");
    property p_start; @(posedge CLK) disable iff (!RSTN) CONV_START |=> !CONV_START; endproperty
    a_start: assert property (p_start) else $error("start too long");
endmodule
bind temp_monitor_regs temp_monitor_regs_assertions chk_i (.CLK(CLK), .RSTN(RSTN), .LINK_CLK(LINK_CLK),
    .XFER_VALID(XFER_VALID), .XFER_BUSY(XFER_BUSY), .XFER_DONE(XFER_DONE), .XFER_RDATA(XFER_RDATA),
    .CONV_START(CONV_START));

// [verif/link_master.sv]
`timescale 1ns/100ps
module link_master (
    input  wire logic            LINK_CLK,
    input  wire logic            XFER_BUSY,
    input  wire logic            XFER_DONE,
    input  wire logic [7:0]      XFER_RDATA,
    output      logic            XFER_VALID,
    output      tmon_pkg::xfer_t XFER_REQ
);
    // idle request lines
    initial begin
        XFER_VALID = 1'b0;
        XFER_REQ = '0;
    end
    // one transfer, valid for one link clock, answer awaited under a bound
    task automatic xfer(input tmon_pkg::xfer_kind_t k, input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge LINK_CLK);
        #1 XFER_VALID = 1'b1;
        XFER_REQ = '{kind: k, data: d};
        @(posedge LINK_CLK);
        #1 XFER_VALID = 1'b0;
        XFER_REQ = ~XFER_REQ;  // released lines do not keep the old value
        while (!XFER_DONE && n < 20) begin
            @(posedge LINK_CLK);
            #1 n++;
        end
        if (XFER_DONE) q = XFER_RDATA;
        else begin
            tb_temp_monitor_regs.err_total++;
            tb_temp_monitor_regs.test_done();
        end
    endtask
endmodule

// [verif/tb_temp_monitor_regs.sv]
`timescale 1ns/100ps
module tb_temp_monitor_regs;
    logic CLK = 0, LINK_CLK = 0, RSTN = 0, CONV_BUSY = 0, CONV_DONE = 0, started = 0;
    logic XFER_VALID, XFER_BUSY, XFER_DONE, CONV_START, CONV_RUN, CRITICAL_OUT_N, EVENT_OUT_N;
    logic [7:0] XFER_RDATA, q;
    tmon_pkg::xfer_t XFER_REQ;
    tmon_pkg::conv_result_t CONV_RESULT = '0;
    tmon_pkg::conv_setup_t setup_w;
    int err_total = 0, checks_done = 0;
    logic [7:0] idx [12] = '{8'h03, 8'h04, 8'h05, 8'h07, 8'h19, 8'h20, 8'h21, 8'h22, 8'hfe, 8'h12, 8'h0f, 8'h30};
    logic [7:0] rv [12] = '{8'h00, 8'h08, 8'h55, 8'h55, 8'h6e, 8'h6e, 8'h0a, 8'h01, 8'h3c, 8'h00, 8'h00, 8'h00};
    // core and link clocks, unrelated phase
    initial forever #4 CLK = ~CLK;
    initial begin
        #6;
        forever #24 LINK_CLK = ~LINK_CLK;
    end
    // catch the start pulse
    always @(posedge CLK) if (CONV_START) started <= 1'b1;
    temp_monitor_regs #(.MAKER_CODE(8'h3c)) dut (.CLK(CLK), .RSTN(RSTN), .LINK_CLK(LINK_CLK),  // arbitrary code
        .XFER_VALID(XFER_VALID), .XFER_REQ(XFER_REQ), .XFER_BUSY(XFER_BUSY), .XFER_DONE(XFER_DONE),
        .XFER_RDATA(XFER_RDATA), .CONV_BUSY(CONV_BUSY), .CONV_DONE(CONV_DONE), .CONV_RESULT(CONV_RESULT),
        .CONV_START(CONV_START), .CONV_RUN(CONV_RUN), .CONV_SETUP(setup_w), .CRITICAL_OUT_N(CRITICAL_OUT_N),
        .EVENT_OUT_N(EVENT_OUT_N));
    link_master bm (.LINK_CLK(LINK_CLK), .XFER_BUSY(XFER_BUSY), .XFER_DONE(XFER_DONE),
        .XFER_RDATA(XFER_RDATA), .XFER_VALID(XFER_VALID), .XFER_REQ(XFER_REQ));
    // compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // index byte then data byte
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bm.xfer(tmon_pkg::KIND_INDEX, a, q);
        bm.xfer(tmon_pkg::KIND_WRITE, d, q);
    endtask
    // index byte then read, compared
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        bm.xfer(tmon_pkg::KIND_INDEX, a, q);
        bm.xfer(tmon_pkg::KIND_READ, 8'h00, q);
        chk(q, exp);
    endtask
    // one converter result, then let flags and pins settle
    task automatic conv(input logic [11:0] l);
        @(posedge CLK);
        #1 CONV_RESULT = '{l, 12'h1b7, 1'b0};
        CONV_DONE = 1'b1;
        @(posedge CLK);
        #1 CONV_DONE = 1'b0;
        repeat (6) @(posedge CLK);
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (4) @(posedge CLK);
        #1 RSTN = 1'b1;
        repeat (2) @(posedge LINK_CLK);
        chk(CONV_RUN, 8'h01);
        bm.xfer(tmon_pkg::KIND_READ, 8'h00, q);
        chk(q, 8'h00);
        foreach (idx[i]) rdc(idx[i], rv[i]);
        wr(8'h0b, 8'h68);
        rdc(8'h05, 8'h68);
        wr(8'h22, 8'hff);
        rdc(8'h22, 8'h8f);
        wr(8'h0f, 8'ha5);
        repeat (4) @(posedge CLK);
        chk(started, 8'h01);
        conv(12'h4a3);
        rdc(8'h00, 8'h4a);
        rdc(8'h01, 8'h1b);
        rdc(8'h10, 8'h70);
        rdc(8'h00, 8'h4a);
        conv(12'h5c8);
        rdc(8'h15, 8'h30);
        rdc(8'h00, 8'h5c);
        @(posedge CLK);
        #1 CONV_BUSY = 1'b1;
        rdc(8'h02, 8'h80);
        @(posedge CLK);
        #1 CONV_BUSY = 1'b0;
        conv(12'h700);
        chk(CRITICAL_OUT_N, 8'h00);
        chk(EVENT_OUT_N, 8'h00);
        rdc(8'h02, 8'h41);
        conv(12'h650);
        chk(CRITICAL_OUT_N, 8'h00);
        conv(12'h640);
        chk(CRITICAL_OUT_N, 8'h01);
        rdc(8'h02, 8'h40);
        rdc(8'h02, 8'h00);
        chk(EVENT_OUT_N, 8'h00);
        bm.xfer(tmon_pkg::KIND_ALERT_ACK, 8'h00, q);
        repeat (6) @(posedge CLK);
        chk(EVENT_OUT_N, 8'h01);
        wr(8'h09, 8'h84);
        chk(setup_w.ext_range, 8'h01);
        conv(12'h700);
        chk(EVENT_OUT_N, 8'h01);
        wr(8'h09, 8'h24);
        chk(EVENT_OUT_N, 8'h00);
        conv(12'h5e0);
        chk(EVENT_OUT_N, 8'h01);
        test_done();
    end
endmodule
